/* File: design/pexc_pkg.sv */
// Shared constants and types for the pipeline exception and stage sequencer.
package pexc_pkg;

  // ==========================================================================
  // Exception sequence
  // ==========================================================================
  typedef enum logic [4:0] {
    PX_IDLE = 5'h01,
    PX_EX1 = 5'h02,
    PX_EX2 = 5'h04,
    PX_EX3 = 5'h08,
    PX_EX4 = 5'h10
  } pexc_seq_t;

  typedef enum logic [2:0] {
    CS_NONE = 3'h0,
    CS_INTR = 3'h1,
    CS_AFETCH = 3'h2,
    CS_ADATA = 3'h3,
    CS_TBUF = 3'h4,
    CS_ILLEGAL = 3'h5,
    CS_SLOT = 3'h6
  } pexc_cause_t;

  // ==========================================================================
  // Instruction classes seen at the decode_stage
  // ==========================================================================
  typedef enum logic [3:0] {
    CL_INT = 4'h0,
    CL_FOP = 4'h1,
    CL_FLONG = 4'h2,
    CL_XLD = 4'h3,
    CL_YLD = 4'h4,
    CL_XST = 4'h5,
    CL_YST = 4'h6,
    CL_SLD = 4'h7,
    CL_SST = 4'h8,
    CL_DSPOP = 4'h9
  } pexc_cls_t;

  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;

  // ==========================================================================
  // Address map and timing
  // ==========================================================================
  localparam logic [31:0] PERIPH_MASK = 32'hFFFF_0000;
  localparam logic [31:0] PERIPH_BASE = 32'hFFFF_0000;
  localparam logic [31:0] PERIPH8_MASK = 32'hFFFF_C000;
  localparam logic [31:0] PERIPH8_BASE = 32'hFFFF_8000;
  localparam logic [3:0] FLONG_E1_CYCLES = 4'hD;
  localparam logic [3:0] FSHORT_E1_CYCLES = 4'h1;

endpackage

/* File: design/pexc_if.sv */
// Carrier between the sequencer core, its float timer and its address checker.
`timescale 1ns/1ps
`default_nettype none
interface pexc_if;
  logic f_issue;
  logic f_long;
  logic f_req;
  logic f_int_dec;
  logic f_stall;
  logic f_e2;
  logic f_drop;
  logic [31:0] a_fetch_addr;
  logic [31:0] a_data_addr;
  logic [1:0] a_data_size;
  logic a_data_en;
  logic a_fetch_err;
  logic a_data_err;

  modport core (output f_issue, f_long, f_req, f_int_dec, a_fetch_addr, a_data_addr, a_data_size, a_data_en,
                input f_stall, f_e2, f_drop, a_fetch_err, a_data_err);
  modport fpu (input f_issue, f_long, f_req, f_int_dec, output f_stall, f_e2, f_drop);
  modport achk (input a_fetch_addr, a_data_addr, a_data_size, a_data_en, output a_fetch_err, a_data_err);
endinterface
`default_nettype wire

/* File: design/pexc_addr_check.sv */
// Instruction fetch and data access address error detection.
`timescale 1ns/1ps
`default_nettype none
module pexc_addr_check (
  pexc_if.achk bus
);
  import pexc_pkg::*;

  function automatic logic in_region(input logic [31:0] a, input logic [31:0] m, input logic [31:0] b);
    in_region = (a & m) == b;
  endfunction

  // Odd fetch address or fetch from the peripheral register area. [RULE6]
  assign bus.a_fetch_err = bus.a_fetch_addr[0] | in_region(bus.a_fetch_addr, PERIPH_MASK, PERIPH_BASE);

  // Misaligned word, misaligned long, or long access to the 8-bit peripheral space. [RULE7]
  assign bus.a_data_err = bus.a_data_en & (
    ((bus.a_data_size == SZ_WORD) & bus.a_data_addr[0]) |
    ((bus.a_data_size == SZ_LONG) & (bus.a_data_addr[1:0] != 2'h0)) |
    ((bus.a_data_size == SZ_LONG) & in_region(bus.a_data_addr, PERIPH8_MASK, PERIPH8_BASE)));
endmodule
`default_nettype wire

/* File: design/pexc_fpu_seq.sv */
// Float first-stage occupancy timer for divide and square root.
`timescale 1ns/1ps
`default_nettype none
module pexc_fpu_seq (
  input wire logic clk_sys,
  input wire logic reset_n,
  pexc_if.fpu bus
);
  import pexc_pkg::*;

  logic [3:0] e1_cnt_r;
  logic e2_r;
  logic drop_r;

  // A float op may only enter once the first float stage frees up; integer
  // instructions in between do not shorten the wait. [RULE15]
  assign bus.f_stall = bus.f_req & (e1_cnt_r > FSHORT_E1_CYCLES);
  assign bus.f_e2 = e2_r;
  assign bus.f_drop = drop_r;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      e1_cnt_r <= 4'h0;
    end else if (bus.f_issue) begin
      e1_cnt_r <= bus.f_long ? FLONG_E1_CYCLES : FSHORT_E1_CYCLES; // [RULE13]
    end else if (e1_cnt_r != 4'h0) begin
      e1_cnt_r <= e1_cnt_r - 4'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      e2_r <= 1'b0;
    end else begin
      e2_r <= (e1_cnt_r == FSHORT_E1_CYCLES);
    end
  end

  // An integer instruction leaves the float pipe after its float decode slot.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      drop_r <= 1'b0;
    end else begin
      drop_r <= bus.f_int_dec; // [RULE14]
    end
  end

  long_e1_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE13]
    (bus.f_issue && bus.f_long) |-> ##14 bus.f_e2)
    else $error("long float op did not reach E2 after 13 E1 cycles");

  float_wait_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // [RULE15]
    (bus.f_issue && bus.f_long) ##12 bus.f_req |-> bus.f_stall)
    else $error("float op entered while divide still held E1");
endmodule
`default_nettype wire

/* File: design/pexc_pipe.sv */
// Exception sequencer and DSP/float stage control for the RISC core pipeline.
// Functional notes
// [RULE1] Interrupt taken at decode; the rest of that instruction becomes the exception sequence.
// [RULE2] Exception sequence: fetch, decode, four execute slots; no delay slot runs.
// [RULE3] One overrun fetch is discarded; handler fetch starts right after the fourth execute.
// [RULE4] Interrupt sources: non-maskable pin, encoded level inputs, on-chip peripherals.
// [RULE5] Address error taken at decode, same six-slot sequence with overrun fetch.
// [RULE6] Fetch from odd address or peripheral register area is a fetch address error.
// [RULE7] Misaligned word/long or long access to 8-bit peripheral space is a data error.
// [RULE8] Translation buffer exception at decode uses the same six-slot sequence.
// [RULE9] Translation buffer causes: miss, invalid, initial page write, protection.
// [RULE10] Illegal instruction may overrun one or two fetches, chosen by the decoded instruction.
// [RULE11] Undefined opcode outside a delay slot raises ordinary illegal instruction.
// [RULE12] Undefined opcode or PC write in a delay slot raises slot illegal.
// [RULE13] Float divide and square root hold the first float stage for 13 cycles.
// [RULE14] Integer instruction after a float op leaves the float pipe after float decode.
// [RULE15] Float op after 2 to 12 integer ops still waits for the long op; the code stalls it only after up to 11.
// [RULE16] X memory load: five stages, DSP write-back, X bus, no fetch contention.
// [RULE17] Y memory load: five stages, DSP write-back, Y bus, no fetch contention.
// [RULE18] X/Y stores use four stages; stall when reading the previous DSP result.
// [RULE19] Single load: five stages, DSP write-back, never stalls a user of the register.
// [RULE20] Single store: four stages; stall when storing the previous DSP result.
// [RULE21] False conditional DSP op skips write-back, timing unchanged.
// [RULE22] Stalls hold fetch and decode and put a bubble into the operate stage.
`timescale 1ns/1ps
`default_nettype none
module pexc_pipe (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic nmi_pin,
  input wire logic [3:0] level_interrupt_inputs,
  input wire logic periph_irq,
  input wire logic [3:0] irq_mask,
  input wire logic dec_valid,
  input wire pexc_pkg::pexc_cls_t dec_cls,
  input wire logic [31:0] dec_pc,
  input wire logic dec_mem_en,
  input wire logic [31:0] dec_mem_addr,
  input wire logic [1:0] dec_mem_size,
  input wire logic dec_undefined,
  input wire logic dec_pc_write,
  input wire logic dec_in_slot,
  input wire logic dec_two_overrun,
  input wire logic dec_cond_false,
  input wire logic dec_uses_dsp_result,
  input wire logic tb_miss,
  input wire logic tb_invalid,
  input wire logic tb_init_write,
  input wire logic tb_protect,
  output logic decode_hold,
  output logic ex_bubble,
  output logic fetch_enable,
  output logic fetch_discard,
  output logic exc_busy,
  output pexc_pkg::pexc_cause_t exc_cause,
  output logic handler_fetch,
  output logic x_bus_access,
  output logic y_bus_access,
  output logic single_bus_access,
  output logic dsp_wb_en,
  output logic fpu_e2,
  output logic fpu_drop
);
  import pexc_pkg::*;

  // ==========================================================================
  // Stage class helpers
  // ==========================================================================
  function automatic logic is_dsp_load(input pexc_cls_t c);
    is_dsp_load = (c == CL_XLD) | (c == CL_YLD) | (c == CL_SLD);
  endfunction

  function automatic logic is_dsp_store(input pexc_cls_t c);
    is_dsp_store = (c == CL_XST) | (c == CL_YST) | (c == CL_SST);
  endfunction

  function automatic logic is_float(input pexc_cls_t c);
    is_float = (c == CL_FOP) | (c == CL_FLONG);
  endfunction

  pexc_if sub ();

  pexc_addr_check u_achk (
    .bus(sub)
  );

  pexc_fpu_seq u_fpu (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .bus(sub)
  );

  // ==========================================================================
  // Interrupt sources
  // ==========================================================================
  // Pins pass three flops; a new level is believed once flops two and three agree.
  logic [2:0] nmi_s_r;
  logic nmi_lvl_r;
  logic nmi_pend_r;
  logic [3:0] lvl_s1_r;
  logic [3:0] lvl_s2_r;
  logic [3:0] lvl_s3_r;
  logic [3:0] lvl_r;
  logic irq_req;
  logic nmi_clr;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      nmi_s_r <= 3'h0;
      nmi_lvl_r <= 1'b0;
    end else begin
      nmi_s_r <= {nmi_s_r[1:0], nmi_pin};
      if (nmi_s_r[1] == nmi_s_r[2]) begin
        nmi_lvl_r <= nmi_s_r[2];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      lvl_s1_r <= 4'h0;
      lvl_s2_r <= 4'h0;
      lvl_s3_r <= 4'h0;
    end else begin
      lvl_s1_r <= level_interrupt_inputs;
      lvl_s2_r <= lvl_s1_r;
      lvl_s3_r <= lvl_s2_r;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lvl
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          lvl_r[gi] <= 1'b0;
        end else if (lvl_s2_r[gi] == lvl_s3_r[gi]) begin
          lvl_r[gi] <= lvl_s3_r[gi];
        end
      end
    end
  endgenerate

  // The non-maskable edge is latched; a new edge in the clearing cycle is kept.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      nmi_pend_r <= 1'b0;
    end else begin
      nmi_pend_r <= ((nmi_s_r[2] == nmi_s_r[1]) & nmi_s_r[2] & ~nmi_lvl_r) | (nmi_pend_r & ~nmi_clr);
    end
  end

  assign irq_req = nmi_pend_r | (lvl_r > irq_mask) | periph_irq; // [RULE4]

  // ==========================================================================
  // Exception selection at the decode_stage
  // ==========================================================================
  pexc_seq_t seq_r;
  pexc_cause_t cause_now;
  logic take;
  logic two_r;
  logic handler_r;
  pexc_cause_t cause_r;
  logic tb_err;
  logic store_hazard;
  logic stall;
  logic accept;

  assign sub.a_fetch_addr = dec_pc;
  assign sub.a_data_addr = dec_mem_addr;
  assign sub.a_data_size = dec_mem_size;
  assign sub.a_data_en = dec_mem_en;
  assign tb_err = tb_miss | tb_invalid | tb_init_write | tb_protect; // [RULE9]

  // Fixed priority among causes, address faults first, interrupts last.
  always_comb begin
    cause_now = CS_NONE;
    if (sub.a_fetch_err) begin
      cause_now = CS_AFETCH; // [RULE6]
    end else if (sub.a_data_err) begin
      cause_now = CS_ADATA; // [RULE7]
    end else if (tb_err) begin
      cause_now = CS_TBUF; // [RULE8]
    end else if (dec_in_slot & (dec_undefined | dec_pc_write)) begin
      cause_now = CS_SLOT; // [RULE12]
    end else if (dec_undefined) begin
      cause_now = CS_ILLEGAL; // [RULE11]
    end else if (irq_req) begin
      cause_now = CS_INTR; // [RULE1]
    end
  end

  // Any cause replaces the decoding instruction's later stages. [RULE1] [RULE5] [RULE8]
  assign take = dec_valid & (seq_r == PX_IDLE) & (cause_now != CS_NONE);
  assign nmi_clr = take & (cause_now == CS_INTR) & nmi_pend_r;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      seq_r <= PX_IDLE;
    end else begin
      unique case (seq_r)
        PX_IDLE: begin
          if (take) begin
            seq_r <= PX_EX1; // [RULE2]
          end
        end
        PX_EX1: begin
          seq_r <= PX_EX2;
        end
        PX_EX2: begin
          seq_r <= PX_EX3;
        end
        PX_EX3: begin
          seq_r <= PX_EX4;
        end
        PX_EX4: begin
          seq_r <= PX_IDLE;
        end
        default: begin
          seq_r <= PX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cause_r <= CS_NONE;
      two_r <= 1'b0;
    end else if (take) begin
      cause_r <= cause_now;
      two_r <= dec_two_overrun & ((cause_now == CS_ILLEGAL) | (cause_now == CS_SLOT)); // [RULE10]
    end
  end

  // Handler fetch goes out in the slot after the fourth execute slot.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      handler_r <= 1'b0;
    end else begin
      handler_r <= (seq_r == PX_EX4); // [RULE3]
    end
  end

  // The fetch running alongside the taken decode is an overrun and is thrown
  // away, so nothing behind the faulting instruction executes as a slot.
  assign fetch_discard = take | ((seq_r == PX_EX1) & two_r); // [RULE2] [RULE3] [RULE10]
  assign fetch_enable = ((seq_r == PX_IDLE) & ~stall) | take | ((seq_r == PX_EX1) & two_r) | handler_r;

  // ==========================================================================
  // Contention stalls
  // ==========================================================================
  logic ex_vld_r;
  pexc_cls_t ex_cls_r;
  logic ex_nowb_r;
  logic ma_vld_r;
  pexc_cls_t ma_cls_r;
  logic ma_nowb_r;
  logic wb_vld_r;
  pexc_cls_t wb_cls_r;
  logic wb_nowb_r;

  // Stores reading the result of the DSP op just ahead of them wait a slot.
  assign store_hazard = is_dsp_store(dec_cls) & dec_uses_dsp_result & ex_vld_r & (ex_cls_r == CL_DSPOP); // [RULE18] [RULE20]
  assign sub.f_req = dec_valid & is_float(dec_cls);
  assign stall = dec_valid & ~take & (store_hazard | sub.f_stall);
  assign accept = dec_valid & (seq_r == PX_IDLE) & ~take & ~stall;

  // Hold fetch and decode; the operate stage gets a bubble while later stages run on. [RULE22]
  assign decode_hold = (seq_r != PX_IDLE) | stall;
  assign ex_bubble = ~accept;

  assign sub.f_issue = accept & is_float(dec_cls);
  assign sub.f_long = dec_cls == CL_FLONG;
  assign sub.f_int_dec = accept & ~is_float(dec_cls); // [RULE14]

  // ==========================================================================
  // Operate, memory access and DSP write-back stages
  // ==========================================================================
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ex_vld_r <= 1'b0;
      ex_cls_r <= CL_INT;
      ex_nowb_r <= 1'b0;
    end else begin
      ex_vld_r <= accept;
      ex_cls_r <= dec_cls;
      ex_nowb_r <= dec_cond_false;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ma_vld_r <= 1'b0;
      ma_cls_r <= CL_INT;
      ma_nowb_r <= 1'b0;
    end else begin
      ma_vld_r <= ex_vld_r;
      ma_cls_r <= ex_cls_r;
      ma_nowb_r <= ex_nowb_r;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wb_vld_r <= 1'b0;
      wb_cls_r <= CL_INT;
      wb_nowb_r <= 1'b0;
    end else begin
      wb_vld_r <= ma_vld_r;
      wb_cls_r <= ma_cls_r;
      wb_nowb_r <= ma_nowb_r;
    end
  end

  // X and Y transfers use their own buses and never gate fetch_enable. [RULE16] [RULE17]
  assign x_bus_access = ma_vld_r & ((ma_cls_r == CL_XLD) | (ma_cls_r == CL_XST));
  assign y_bus_access = ma_vld_r & ((ma_cls_r == CL_YLD) | (ma_cls_r == CL_YST));
  assign single_bus_access = ma_vld_r & ((ma_cls_r == CL_SLD) | (ma_cls_r == CL_SST));

  // Loads end in DSP write-back; a false condition drops it without moving any stage.
  assign dsp_wb_en = wb_vld_r & (is_dsp_load(wb_cls_r) | (wb_cls_r == CL_DSPOP)) & ~wb_nowb_r; // [RULE19] [RULE21]

  assign exc_busy = seq_r != PX_IDLE;
  assign exc_cause = cause_r;
  assign handler_fetch = handler_r;
  assign fpu_e2 = sub.f_e2;
  assign fpu_drop = sub.f_drop;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  seq_length_a: assert property (take |=> exc_busy [*4] ##1 (!exc_busy && handler_fetch)) // [RULE2]
    else $error("exception sequence not four execute slots");

  handler_slot_a: assert property (take |-> ##5 handler_fetch && fetch_enable) // [RULE3]
    else $error("handler fetch not in slot after last execute");

  no_slot_run_a: assert property (take |-> fetch_discard ##1 ex_bubble [*4]) // [RULE2]
    else $error("instruction ran during exception sequence");

  data_err_a: assert property ((take && dec_mem_en && dec_mem_size == SZ_LONG && dec_mem_addr[1:0] != 2'h0) // [RULE7]
    && !sub.a_fetch_err |=> exc_cause == CS_ADATA)
    else $error("misaligned long access not flagged");

  slot_illegal_a: assert property ((take && dec_in_slot && dec_pc_write && !tb_err) // [RULE12]
    && !sub.a_fetch_err && !sub.a_data_err |=> exc_cause == CS_SLOT)
    else $error("pc write in delay slot not slot illegal");

  store_stall_a: assert property ((store_hazard && dec_valid && !exc_busy && !take) |-> decode_hold && ex_bubble) // [RULE20]
    else $error("dsp store did not stall on previous result");

  load_stages_a: assert property ((accept && dec_cls == CL_XLD && !dec_cond_false) |-> ##2 x_bus_access ##1 dsp_wb_en) // [RULE16]
    else $error("x load stage timing wrong");

  cond_skip_a: assert property ((accept && dec_cls == CL_DSPOP && dec_cond_false) |-> ##3 (wb_vld_r && !dsp_wb_en)) // [RULE21]
    else $error("false conditional op wrote back");

  single_nostall_a: assert property ((dec_valid && dec_cls == CL_SLD && !exc_busy && !take) |-> !decode_hold) // [RULE19]
    else $error("single load stalled");
endmodule
`default_nettype wire

/* File: test/pexc_irq_model.sv */
// Behavioural model of the interrupt sources that face the sequencer.
`timescale 1ns/1ps
`default_nettype none
module pexc_irq_model (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic fire_nmi,
  input wire logic [3:0] lvl_req,
  input wire logic per_req,
  output logic nmi_pin,
  output logic [3:0] level_interrupt_inputs,
  output logic periph_irq
);
  // ==========================================================================
  // Request sources
  // ==========================================================================
  logic [2:0] nmi_r;
  logic [3:0] lvl_r;
  logic per_r;

  // The pin is held for four cycles so that the three-flop filter sees a clean rise.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      nmi_r <= 3'h0;
    end else if (fire_nmi) begin
      nmi_r <= 3'h4;
    end else if (nmi_r != 3'h0) begin
      nmi_r <= nmi_r - 3'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      lvl_r <= 4'h0;
      per_r <= 1'b0;
    end else begin
      lvl_r <= lvl_req;
      per_r <= per_req;
    end
  end

  assign nmi_pin = (nmi_r != 3'h0);
  assign level_interrupt_inputs = lvl_r;
  assign periph_irq = per_r;
endmodule
`default_nettype wire

/* File: test/testbench.sv */
// Self-checking bench for the exception sequencer and DSP/float stage control.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pexc_pkg::*;

  // ==========================================================================
  // Stimulus and design
  // ==========================================================================
  typedef struct packed {
    logic [31:0] pc;
    logic [31:0] addr;
    logic [1:0] size;
    logic mem;
    logic [7:0] fl;
    pexc_cause_t exp;
  } pexc_row_t;

  // Flag order: undefined, pc write, in slot, two overrun, miss, invalid, initial write, protect.
  localparam pexc_row_t ROWS [16] = '{
    '{32'h0000_1000, 32'h0000_0000, SZ_BYTE, 1'h0, 8'h00, CS_NONE},
    '{32'h0000_1001, 32'h0000_0000, SZ_BYTE, 1'h0, 8'h00, CS_AFETCH},
    '{32'hFFFF_0010, 32'h0000_0000, SZ_BYTE, 1'h0, 8'h00, CS_AFETCH},
    '{32'h0000_1000, 32'h0000_2001, SZ_WORD, 1'h1, 8'h00, CS_ADATA},
    '{32'h0000_1000, 32'h0000_2002, SZ_LONG, 1'h1, 8'h00, CS_ADATA},
    '{32'h0000_1000, 32'hFFFF_8000, SZ_LONG, 1'h1, 8'h00, CS_ADATA},
    '{32'h0000_1000, 32'hFFFF_8002, SZ_WORD, 1'h1, 8'h00, CS_NONE},
    '{32'h0000_1000, 32'h0000_0000, SZ_BYTE, 1'h0, 8'h08, CS_TBUF},
    '{32'h0000_1000, 32'h0000_0000, SZ_BYTE, 1'h0, 8'h04, CS_TBUF},
    '{32'h0000_1000, 32'h0000_0000, SZ_BYTE, 1'h0, 8'h02, CS_TBUF},
    '{32'h0000_1000, 32'h0000_0000, SZ_BYTE, 1'h0, 8'h01, CS_TBUF},
    '{32'h0000_1000, 32'h0000_0000, SZ_BYTE, 1'h0, 8'h80, CS_ILLEGAL},
    '{32'h0000_1000, 32'h0000_0000, SZ_BYTE, 1'h0, 8'hA0, CS_SLOT},
    '{32'h0000_1000, 32'h0000_0000, SZ_BYTE, 1'h0, 8'h60, CS_SLOT},
    '{32'h0000_1000, 32'h0000_0000, SZ_BYTE, 1'h0, 8'h90, CS_ILLEGAL},
    '{32'h0000_1000, 32'h0000_0000, SZ_BYTE, 1'h0, 8'h40, CS_NONE}
  };
  localparam pexc_row_t IRQ_ROW = '{32'h0000_1000, 32'h0000_0000, SZ_BYTE, 1'h0, 8'h00, CS_INTR};
  localparam pexc_row_t QUIET_ROW = '{32'h0000_1000, 32'h0000_0000, SZ_BYTE, 1'h0, 8'h00, CS_NONE};
  localparam pexc_cls_t LDS [3] = '{CL_XLD, CL_YLD, CL_SLD};
  localparam pexc_cls_t STS [3] = '{CL_XST, CL_YST, CL_SST};

  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic fire_nmi = 1'b0;
  logic [3:0] lvl_req = 4'h0;
  logic per_req = 1'b0;
  logic [3:0] irq_mask = 4'h3;
  logic dec_valid = 1'b0;
  pexc_cls_t dec_cls = CL_INT;
  logic [31:0] dec_pc = 32'h0000_0000;
  logic dec_mem_en = 1'b0;
  logic [31:0] dec_mem_addr = 32'h0000_0000;
  logic [1:0] dec_mem_size = SZ_BYTE;
  logic dec_cond_false = 1'b0;
  logic dec_uses_dsp_result = 1'b0;
  logic [7:0] fl_q = 8'h00;
  wire logic dec_undefined, dec_pc_write, dec_in_slot, dec_two_overrun, tb_miss, tb_invalid, tb_init_write, tb_protect;
  wire logic nmi_pin, periph_irq;
  wire logic [3:0] level_interrupt_inputs;
  logic decode_hold, ex_bubble, fetch_enable, fetch_discard, exc_busy, handler_fetch;
  logic x_bus_access, y_bus_access, single_bus_access, dsp_wb_en, fpu_e2, fpu_drop;
  pexc_cause_t exc_cause;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int n;

  assign {dec_undefined, dec_pc_write, dec_in_slot, dec_two_overrun, tb_miss, tb_invalid, tb_init_write, tb_protect} = fl_q;

  always #4 clk_sys = ~clk_sys;

  pexc_irq_model pexc_irq_model_inst (.clk_sys(clk_sys), .reset_n(reset_n), .fire_nmi(fire_nmi), .lvl_req(lvl_req),
    .per_req(per_req), .nmi_pin(nmi_pin), .level_interrupt_inputs(level_interrupt_inputs), .periph_irq(periph_irq));

  pexc_pipe pexc_pipe_inst (.clk_sys(clk_sys), .reset_n(reset_n), .nmi_pin(nmi_pin),
    .level_interrupt_inputs(level_interrupt_inputs), .periph_irq(periph_irq), .irq_mask(irq_mask),
    .dec_valid(dec_valid), .dec_cls(dec_cls), .dec_pc(dec_pc), .dec_mem_en(dec_mem_en), .dec_mem_addr(dec_mem_addr),
    .dec_mem_size(dec_mem_size), .dec_undefined(dec_undefined), .dec_pc_write(dec_pc_write),
    .dec_in_slot(dec_in_slot), .dec_two_overrun(dec_two_overrun), .dec_cond_false(dec_cond_false),
    .dec_uses_dsp_result(dec_uses_dsp_result), .tb_miss(tb_miss), .tb_invalid(tb_invalid),
    .tb_init_write(tb_init_write), .tb_protect(tb_protect), .decode_hold(decode_hold), .ex_bubble(ex_bubble),
    .fetch_enable(fetch_enable), .fetch_discard(fetch_discard), .exc_busy(exc_busy), .exc_cause(exc_cause),
    .handler_fetch(handler_fetch), .x_bus_access(x_bus_access), .y_bus_access(y_bus_access),
    .single_bus_access(single_bus_access), .dsp_wb_en(dsp_wb_en), .fpu_e2(fpu_e2), .fpu_drop(fpu_drop));

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %s expected %0h seen %0h", name, e, g);
    end
  endtask

  task automatic put(input pexc_cls_t c, input logic u, input logic cf);
    @(posedge clk_sys);
    dec_valid <= 1'b1;
    dec_cls <= c;
    dec_uses_dsp_result <= u;
    dec_cond_false <= cf;
  endtask

  task automatic idle();
    @(posedge clk_sys);
    dec_valid <= 1'b0;
    fl_q <= 8'h00;
  endtask

  // Presents one instruction for a single cycle and follows the exception walk if one is due.
  task automatic issue(input pexc_row_t r);
    logic exc;
    exc = (r.exp != CS_NONE);
    put(CL_INT, 1'b0, 1'b0);
    dec_pc <= r.pc;
    dec_mem_addr <= r.addr;
    dec_mem_size <= r.size;
    dec_mem_en <= r.mem;
    fl_q <= r.fl;
    #1;
    chk("fetch_discard", exc, fetch_discard);
    chk("ex_bubble", exc, ex_bubble);
    idle();
    #1;
    if (exc) begin
      chk("second_overrun", r.fl[4], fetch_discard);
      repeat (4) begin
        chk("exc_busy", 1'b1, exc_busy);
        @(posedge clk_sys);
        #1;
      end
      chk("handler_fetch", 1'b1, handler_fetch);
      chk("exc_cause", r.exp, exc_cause);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // The whole sequence needs well under a thousand cycles.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      conclude();
    end
  end

  // ==========================================================================
  // Sequence
  // ==========================================================================
  initial begin
    repeat (11) @(posedge clk_sys);
    #1;
    chk("reset_busy", 1'b0, exc_busy);
    chk("reset_cause", CS_NONE, exc_cause);
    chk("reset_fetch_enable", 1'b1, fetch_enable);
    @(posedge clk_sys);
    reset_n <= 1'b1;
    $display("test reset done");
    foreach (ROWS[i]) begin
      issue(ROWS[i]);
      $display("test row %0d done", i);
    end
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_sys);
      fire_nmi <= (k == 0);
      lvl_req <= (k == 1) ? 4'h5 : 4'h0;
      per_req <= (k == 2);
      @(posedge clk_sys);
      fire_nmi <= 1'b0;
      repeat (6) @(posedge clk_sys);
      issue(IRQ_ROW);
      @(posedge clk_sys);
      lvl_req <= 4'h0;
      per_req <= 1'b0;
      $display("test interrupt source %0d done", k);
    end
    @(posedge clk_sys);
    lvl_req <= 4'h2;
    repeat (6) @(posedge clk_sys);
    issue(QUIET_ROW);
    lvl_req <= 4'h0;
    $display("test masked level done");
    for (int k = 0; k < 3; k++) begin
      put(LDS[k], 1'b0, k == 2);
      put(CL_INT, 1'b0, 1'b0);
      #1;
      chk("load_user_bubble", 1'b0, ex_bubble);
      idle();
      #1;
      chk("load_bus", 1'b1, (k == 0) ? x_bus_access : (k == 1) ? y_bus_access : single_bus_access);
      @(posedge clk_sys);
      #1;
      chk("dsp_wb_en", k != 2, dsp_wb_en);
      put(CL_DSPOP, 1'b0, k == 2);
      put(STS[k], 1'b1, 1'b0);
      #1;
      chk("store_hold", 1'b1, decode_hold);
      chk("store_bubble", 1'b1, ex_bubble);
      @(posedge clk_sys);
      #1;
      chk("store_accept", 1'b0, ex_bubble);
      idle();
      $display("test dsp class %0d done", k);
    end
    put(CL_FLONG, 1'b0, 1'b0);
    put(CL_INT, 1'b0, 1'b0);
    @(posedge clk_sys);
    #1;
    chk("fpu_drop", 1'b1, fpu_drop);
    put(CL_FOP, 1'b0, 1'b0);
    #1;
    n = 3;
    while (decode_hold === 1'b1 && n < 40) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk("float_wait", 32'd13, n);
    idle();
    #1;
    chk("fpu_e2", 1'b1, fpu_e2);
    $display("test float timing done");
    repeat (4) @(posedge clk_sys);
    conclude();
  end
endmodule
`default_nettype wire
